// ===== hdl/bcsc_status_class.sv
// Purpose: configuration status word, command enables and class code word
// Assumes: event inputs are one-cycle pulses from logic on the same clock
// Notes:   write-one-to-clear on the status flags; set beats clear
`timescale 1ns/10ps
module bcsc_status_class #(
  parameter logic [7:0] SILICON_REVISION = 8'h01 // arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [5:0]  cfgIndex,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWriteData,
  output logic      [31:0] cfgReadData,
  output logic             cfgReadValid,
  input  wire logic        rxPoisonedTlp,
  input  wire logic        txErrorMessage,
  input  wire logic        rxCplUnsupported,
  input  wire logic        rxCplAbort,
  input  wire logic        txCplAbort,
  input  wire logic        rxPoisonedCplData,
  input  wire logic        poisonedWriteFwd,
  output logic             parityResponseEnable,
  output logic             systemErrorReportEnable
);
  import bcsc_pkg::*;

  // ****************************************
  // command enables
  // ****************************************
  logic [15:0] command_r;
  logic [15:0] flags_r;
  logic [15:0] flags_nxt;
  logic [15:0] setMask;
  logic [15:0] clearMask;
  logic [15:0] statusWord;
  logic [31:0] classWord;
  logic        hitCmd;

  // one decoder shared by the write and read paths so they cannot disagree on the map
  function automatic logic indexMatches(input logic [5:0] index,
                                        input logic [5:0] target);
    return index == target;
  endfunction

  assign hitCmd = cfgWrite && indexMatches(cfgIndex, CMD_STATUS_IDX);

  always_ff @(posedge clock) begin
    if (rst) begin
      command_r <= COMMAND_RESET_VALUE;
    end else if (hitCmd) begin
      if (cfgByteEn[0]) begin
        command_r[PARITY_ENABLE_BIT] <= cfgWriteData[PARITY_ENABLE_BIT];
      end
      if (cfgByteEn[1]) begin
        command_r[SYSERR_ENABLE_BIT] <= cfgWriteData[SYSERR_ENABLE_BIT];
      end
    end
  end

  assign parityResponseEnable    = command_r[PARITY_ENABLE_BIT];
  assign systemErrorReportEnable = command_r[SYSERR_ENABLE_BIT];

  // ****************************************
  // status flags
  // ****************************************
  always_comb begin
    setMask = 16'h0000;
    setMask[DETECTED_PARITY_BIT]  = rxPoisonedTlp;
    setMask[SIGNALLED_SYSERR_BIT] = txErrorMessage && systemErrorReportEnable;
    setMask[RX_MASTER_ABORT_BIT]  = rxCplUnsupported;
    setMask[RX_TARGET_ABORT_BIT]  = rxCplAbort;
    setMask[TX_TARGET_ABORT_BIT]  = txCplAbort;
    setMask[DATA_PARITY_BIT]      = parityResponseEnable
                                    && (rxPoisonedCplData || poisonedWriteFwd);
  end

  // status lives in bytes 2 and 3 of the dword at the command index
  always_comb begin
    clearMask = 16'h0000;
    if (hitCmd) begin
      clearMask[7:0]  = cfgByteEn[2] ? cfgWriteData[23:16] : 8'h00;
      clearMask[15:8] = cfgByteEn[3] ? cfgWriteData[31:24] : 8'h00;
    end
  end

  // set is applied after clear so a coincident event survives
  assign flags_nxt = ((flags_r & ~clearMask) | setMask) & STATUS_FLAG_MASK;

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= STATUS_RESET_VALUE & STATUS_FLAG_MASK;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // fixed bits come only from the constant, so writes cannot reach them
  assign statusWord = flags_r | STATUS_FIXED_VALUE;
  assign classWord  = {BASE_CATEGORY_VALUE, SUBCLASS_VALUE,
                       PROG_IF_VALUE, SILICON_REVISION};

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      cfgReadData  <= UNMAPPED_READ_VALUE;
      cfgReadValid <= 1'b0;
    end else begin
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        if (indexMatches(cfgIndex, CMD_STATUS_IDX)) begin
          cfgReadData <= {statusWord, command_r};
        end else if (indexMatches(cfgIndex, CLASS_REV_IDX)) begin
          cfgReadData <= classWord;
        end else begin
          cfgReadData <= UNMAPPED_READ_VALUE;
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_PARITY_ANY: assert property (@(posedge clock) disable iff (rst)
    rxPoisonedTlp |=> flags_r[DETECTED_PARITY_BIT])
    else $error("detected parity flag not set");
  AST_SYSERR_GATED: assert property (@(posedge clock) disable iff (rst)
    (!$past(flags_r[SIGNALLED_SYSERR_BIT]) && flags_r[SIGNALLED_SYSERR_BIT])
    |-> $past(txErrorMessage && systemErrorReportEnable))
    else $error("system error flag set without enabled message");
  AST_MASTER_ABORT: assert property (@(posedge clock) disable iff (rst)
    rxCplUnsupported |=> flags_r[RX_MASTER_ABORT_BIT])
    else $error("master abort flag not set");
  AST_RX_TABORT: assert property (@(posedge clock) disable iff (rst)
    rxCplAbort |=> flags_r[RX_TARGET_ABORT_BIT])
    else $error("received target abort flag not set");
  AST_TX_TABORT: assert property (@(posedge clock) disable iff (rst)
    txCplAbort |=> flags_r[TX_TARGET_ABORT_BIT])
    else $error("signalled target abort flag not set");
  AST_DATA_PARITY_GATED: assert property (@(posedge clock) disable iff (rst)
    ((rxPoisonedCplData || poisonedWriteFwd) && !parityResponseEnable
     && !flags_r[DATA_PARITY_BIT]) |=> !flags_r[DATA_PARITY_BIT])
    else $error("data parity flag set while response disabled");
  AST_FIXED_BITS: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX)
    |=> (cfgReadData[31:16] & 16'h06FF) == 16'h0010)
    else $error("fixed status bits wrong");
  AST_CLASS_READ: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CLASS_REV_IDX) |=> cfgReadValid
    && cfgReadData[31:8] == 24'h060400)
    else $error("class code read wrong");
  AST_CLEAR_STAYS: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && cfgByteEn[3] && cfgWriteData[31] && !rxPoisonedTlp)
    ##1 !rxPoisonedTlp [*2] |-> !flags_r[DETECTED_PARITY_BIT])
    else $error("cleared flag came back without event");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && cfgByteEn[3] && cfgWriteData[28] && rxCplAbort)
    |=> flags_r[RX_TARGET_ABORT_BIT])
    else $error("event lost against clear");
  AST_ENABLE_RESET: assert property (@(posedge clock)
    rst |=> command_r == COMMAND_RESET_VALUE)
    else $error("command enables not zero after reset");

  AST_SERR_ENABLE_RESET: assert property (@(posedge clock)
    rst |=> !systemErrorReportEnable)
    else $error("system error enable not zero after reset");

  AST_FLAGS_RESET: assert property (@(posedge clock)
    rst |=> flags_r == 16'h0000)
    else $error("status flags not clear after reset");

  AST_READ_RESET: assert property (@(posedge clock)
    rst |=> !cfgReadValid && cfgReadData == 32'h00000000)
    else $error("read outputs not idle after reset");

  // ****************************************
  // command enable checks
  // ****************************************
  AST_PARITY_EN_WRITE: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && cfgByteEn[0])
    |=> parityResponseEnable == $past(cfgWriteData[PARITY_ENABLE_BIT]))
    else $error("parity response enable did not take the written value");

  AST_SERR_EN_WRITE: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && cfgByteEn[1])
    |=> systemErrorReportEnable == $past(cfgWriteData[SYSERR_ENABLE_BIT]))
    else $error("system error enable did not take the written value");

  AST_PARITY_EN_KEEP: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && !cfgByteEn[0]) |=> $stable(parityResponseEnable))
    else $error("parity response enable changed without its byte enable");

  AST_SERR_EN_KEEP: assert property (@(posedge clock) disable iff (rst)
    (hitCmd && !cfgByteEn[1]) |=> $stable(systemErrorReportEnable))
    else $error("system error enable changed without its byte enable");

  AST_ENABLES_HOLD: assert property (@(posedge clock) disable iff (rst)
    !hitCmd |=> $stable(command_r))
    else $error("command enables changed without a write");

  AST_CLASS_WRITE_IGNORED: assert property (@(posedge clock) disable iff (rst)
    (cfgWrite && cfgIndex == CLASS_REV_IDX) |=> $stable(command_r))
    else $error("class word write reached the command enables");

  AST_COMMAND_UNUSED: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX)
    |=> (cfgReadData[15:0] & 16'hFEBF) == 16'h0000)
    else $error("unused command bits read nonzero");

  // ****************************************
  // event flags, enabled and disabled cases
  // ****************************************
  AST_SYSERR_SET: assert property (@(posedge clock) disable iff (rst)
    (txErrorMessage && systemErrorReportEnable) |=> flags_r[SIGNALLED_SYSERR_BIT])
    else $error("enabled error message did not set system error flag");

  AST_SYSERR_OFF: assert property (@(posedge clock) disable iff (rst)
    (txErrorMessage && !systemErrorReportEnable && !flags_r[SIGNALLED_SYSERR_BIT])
    |=> !flags_r[SIGNALLED_SYSERR_BIT])
    else $error("system error flag set while reporting disabled");

  AST_DATA_PARITY_SET: assert property (@(posedge clock) disable iff (rst)
    (parityResponseEnable && (rxPoisonedCplData || poisonedWriteFwd))
    |=> flags_r[DATA_PARITY_BIT])
    else $error("data parity flag not set while response enabled");

  // ****************************************
  // per-flag set, clear and hold
  // ****************************************
  // each clearable bit gets the same three checks; fixed bits have no flop to watch
  for (genvar b = 0; b < $bits(flags_r); b++) begin : g_flag
    if (STATUS_FLAG_MASK[b]) begin : g_live
      AST_FLAG_SET: assert property (@(posedge clock) disable iff (rst)
        setMask[b] |=> flags_r[b])
        else $error("flag event was lost");

      AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (rst)
        (clearMask[b] && !setMask[b]) |=> !flags_r[b])
        else $error("flag did not clear");

      AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (rst)
        (!clearMask[b] && !setMask[b]) |=> $stable(flags_r[b]))
        else $error("flag changed without event or clear");
    end
  end

  // ****************************************
  // status word as read at the pins
  // ****************************************
  // these watch the read register, not statusWord, so a slip in the read mux shows
  AST_SELECT_TIMING: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX) |=> cfgReadData[26:25] == 2'b00)
    else $error("select timing field not zero");

  AST_CAPABLE_ZERO: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX)
    |=> cfgReadData[23] == 1'b0 && cfgReadData[21] == 1'b0)
    else $error("capability bits not zero");

  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX)
    |=> cfgReadData[22] == 1'b0 && cfgReadData[18:16] == 3'b000)
    else $error("reserved status bits not zero");

  AST_CHAIN_ONE: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX) |=> cfgReadData[20] == 1'b1)
    else $error("capability chain bit not one");

  AST_INT_STATUS_ZERO: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX) |=> cfgReadData[19] == 1'b0)
    else $error("interrupt status bit not zero");

  AST_FLAGS_READ: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CMD_STATUS_IDX)
    |=> (cfgReadData[31:16] & 16'hF900) == $past(flags_r))
    else $error("status read does not show the flags");

  // ****************************************
  // class word fields
  // ****************************************
  AST_BASE_CATEGORY: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CLASS_REV_IDX) |=> cfgReadData[31:24] == 8'h06)
    else $error("base category field wrong");

  AST_SUBCLASS: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CLASS_REV_IDX) |=> cfgReadData[23:16] == 8'h04)
    else $error("subclass field wrong");

  AST_PROG_IF: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CLASS_REV_IDX) |=> cfgReadData[15:8] == 8'h00)
    else $error("programming interface field not zero");

  AST_REVISION: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex == CLASS_REV_IDX) |=> cfgReadData[7:0] == SILICON_REVISION)
    else $error("silicon revision field wrong");

  // ****************************************
  // read handshake
  // ****************************************
  AST_READ_PULSE: assert property (@(posedge clock) disable iff (rst)
    cfgRead |=> cfgReadValid)
    else $error("read not answered the next cycle");

  AST_READ_IDLE: assert property (@(posedge clock) disable iff (rst)
    !cfgRead |=> !cfgReadValid && $stable(cfgReadData))
    else $error("read outputs moved without a read");

  AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (rst)
    (cfgRead && cfgIndex != CMD_STATUS_IDX && cfgIndex != CLASS_REV_IDX)
    |=> cfgReadData == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

// ===== hdl/bcsc_pkg.sv
// Purpose: constants for the bridge configuration status and class block
// Assumes: configuration accesses arrive as dword index plus byte enables
// Notes:   status word sits in the upper half of the dword at 04h
package bcsc_pkg;
  // dword indices of configuration space
  localparam logic [5:0]  CMD_STATUS_IDX      = 6'h01;
  localparam logic [5:0]  CLASS_REV_IDX       = 6'h02;
  // command word fields
  localparam int          PARITY_ENABLE_BIT   = 6;
  localparam int          SYSERR_ENABLE_BIT   = 8;
  // status word fields
  localparam int          DETECTED_PARITY_BIT = 15;
  localparam int          SIGNALLED_SYSERR_BIT = 14;
  localparam int          RX_MASTER_ABORT_BIT = 13;
  localparam int          RX_TARGET_ABORT_BIT = 12;
  localparam int          TX_TARGET_ABORT_BIT = 11;
  localparam int          DATA_PARITY_BIT     = 8;
  localparam logic [15:0] STATUS_FIXED_VALUE  = 16'h0010;
  localparam logic [15:0] STATUS_FLAG_MASK    = 16'hF900;
  localparam logic [15:0] STATUS_RESET_VALUE  = 16'h0010;
  localparam logic [15:0] COMMAND_RESET_VALUE = 16'h0000;
  localparam logic [15:0] COMMAND_RW_MASK     = 16'h0140;
  // class code fields
  localparam logic [7:0]  BASE_CATEGORY_VALUE = 8'h06;
  localparam logic [7:0]  SUBCLASS_VALUE      = 8'h04;
  localparam logic [7:0]  PROG_IF_VALUE       = 8'h00;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;
endpackage

// ===== sim/bridge_config_status_class_tb_top.sv
// Purpose: self-checking bench for the status word, enables and class word
// Assumes: inputs change at the falling edge; read data is valid the cycle after
// Notes:   assertions live beside the design logic, none here
`timescale 1ns/10ps
module bridge_config_status_class_tb_top;
  import bcsc_pkg::*;
  typedef struct packed {logic [6:0] ev; logic [15:0] cmd; logic [15:0] stat;} bcsc_row_s;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cfgRead = 1'b0;
  logic        cfgWrite = 1'b0;
  logic [5:0]  cfgIndex = 6'h00;
  logic [3:0]  cfgByteEn = 4'h0;
  logic [31:0] cfgWriteData = 32'h00000000;
  logic [31:0] cfgReadData;
  logic        cfgReadValid;
  logic [6:0]  ev = 7'h00;
  logic        parityResponseEnable;
  logic        systemErrorReportEnable;
  int          n_errors = 0;
  int          total_checks = 0;
  // event order: poisoned tlp, error message, unsupported, abort rx, abort tx, poisoned cpl, write
  bcsc_row_s   rows [13] = '{'{7'h40, 16'h0000, 16'h8010}, '{7'h20, 16'h0000, 16'h0010},
    '{7'h10, 16'h0000, 16'h2010}, '{7'h08, 16'h0000, 16'h1010}, '{7'h04, 16'h0000, 16'h0810},
    '{7'h02, 16'h0000, 16'h0010}, '{7'h01, 16'h0000, 16'h0010}, '{7'h20, 16'h0100, 16'h4010},
    '{7'h20, 16'h0040, 16'h0010}, '{7'h02, 16'h0040, 16'h0110}, '{7'h01, 16'h0040, 16'h0110},
    '{7'h02, 16'h0100, 16'h0010}, '{7'h40, 16'h0040, 16'h8010}};

  always #5 clock = ~clock;

  bcsc_status_class #(.SILICON_REVISION(8'h5A)) dut (
    .clock(clock), .rst(rst), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
    .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .cfgReadValid(cfgReadValid), .rxPoisonedTlp(ev[6]), .txErrorMessage(ev[5]),
    .rxCplUnsupported(ev[4]), .rxCplAbort(ev[3]), .txCplAbort(ev[2]),
    .rxPoisonedCplData(ev[1]), .poisonedWriteFwd(ev[0]),
    .parityResponseEnable(parityResponseEnable),
    .systemErrorReportEnable(systemErrorReportEnable));

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle request pulse; returns at the falling edge after the taking edge
  task automatic op(input logic r, input logic w, input logic [5:0] idx, input logic [3:0] be,
                    input logic [31:0] d, input logic [6:0] e);
    @(negedge clock);
    cfgRead = r;
    cfgWrite = w;
    cfgIndex = idx;
    cfgByteEn = be;
    cfgWriteData = d;
    ev = e;
    @(negedge clock);
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    ev = 7'h00;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    op(1'b1, 1'b0, idx, 4'h0, 32'h00000000, 7'h00);
    chk1(cfgReadValid, 1'b1);
    chk32(cfgReadData, exp);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    rd(6'h01, 32'h00100000);
    rd(6'h02, 32'h0604005A);
    op(1'b0, 1'b1, 6'h02, 4'hF, 32'hFFFFFFFF, 7'h00);
    rd(6'h02, 32'h0604005A);
    rd(6'h03, 32'h00000000);
    op(1'b0, 1'b1, 6'h01, 4'hF, 32'hFFFFFFFF, 7'h00);
    rd(6'h01, 32'h00100140);
    $display("fixed fields test done");
    foreach (rows[i]) begin
      op(1'b0, 1'b1, 6'h01, 4'h3, {16'h0000, rows[i].cmd}, 7'h00);
      chk1(parityResponseEnable, rows[i].cmd[6]);
      chk1(systemErrorReportEnable, rows[i].cmd[8]);
      op(1'b0, 1'b0, 6'h00, 4'h0, 32'h00000000, rows[i].ev);
      rd(6'h01, {rows[i].stat, rows[i].cmd});
      op(1'b0, 1'b1, 6'h01, 4'hC, 32'hFFFF0000, 7'h00);
      rd(6'h01, {16'h0010, rows[i].cmd});
    end
    $display("event rows test done");
    // clear and event in one cycle: the event must survive
    op(1'b0, 1'b1, 6'h01, 4'hC, 32'hFFFF0000, 7'h08);
    rd(6'h01, 32'h10100040);
    op(1'b0, 1'b1, 6'h01, 4'h3, 32'h00000140, 7'h00);
    chk1(systemErrorReportEnable, 1'b1);
    repeat (2) @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk1(parityResponseEnable, 1'b0);
    chk1(systemErrorReportEnable, 1'b0);
    rd(6'h01, 32'h00100000);
    $display("reset and collision test done");
    results;
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    results;
  end
endmodule
